// ===== hw/general_timers.sv
/*
 * Timer subsystem: two 12-bit slow timers (chainable), two 32-bit timers on
 * the selectable system clock, a common match line, maskable interrupts and
 * a 10-bit supervision countdown with a warning and a system reset.
 * Assumes an APB master on pclk; the reset output must feed system reset.
 */
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// Contract
// - Two 12-bit timers tick at slow oscillator divided by two.
// - Two 32-bit timers tick on the fast oscillator domain.
// - Timers and watchdog are configured through a 32-bit APB slave.
// - Each timer has one match register and no capture logic.
// - One shared output line carries match events of all four timers.
// - The second 12-bit timer may chain on the first; others cannot.
// - Every timer runs single-shot or free-running, chosen by software.
// - Each timer raises a timeout interrupt with its own mask bit.
// - The 32-bit timers follow the system clock: 20, 10 or 5 MHz.
// - Watchdog is a 10-bit counter at slow oscillator divided by 128.
// - An enabled watchdog that is not reloaded asserts system reset.
// - After a watchdog reset the watchdog is disabled without software.
// - Watchdog raises a non-maskable interrupt at a preset count.
// - Software can gate off the clock that feeds the timers.
module general_timers
    import timer_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq_q,
    output logic             nmi_q,
    output logic             sys_reset_q,
    output logic             timer_out_q
);

    logic [31:0]       ctrl_q;
    logic [31:0]       stat_q;
    logic [31:0]       mask_q;
    logic [1:0]        tctl_q [4];
    logic [31:0]       match_q [4];
    logic [31:0]       cnt [4];
    logic [3:0]        hit;
    logic [3:0]        start;
    logic              slow_tick;
    logic              fast_tick;
    logic              wd_tick;
    logic              gate;
    logic              slow_gated;
    logic              fast_gated;
    logic [WD_W-1:0]   wd_cnt_q;
    logic [WD_W-1:0]   wd_warn_q;
    wd_state_t         wd_state_q;
    logic [HOLD_W-1:0] hold_q;
    logic              access;
    logic              wr;
    logic              feed;
    logic              warn_evt;
    logic [32:0]       rd_word;

    // Divider length for the system clock that paces the 32-bit timers.
    function automatic logic [DIV_W-1:0] fast_len(input logic [1:0] sel);
        logic [DIV_W-1:0] len;
        len = DIV_W'(FAST_DIV - 1);
        case (sel)
            SYS_20: len = DIV_W'(FAST_DIV - 1);
            SYS_10: len = DIV_W'(2 * FAST_DIV - 1);
            SYS_5:  len = DIV_W'(4 * FAST_DIV - 1);
            default: len = DIV_W'(FAST_DIV - 1);
        endcase
        return len;
    endfunction : fast_len

    // Read decode; the top bit flags an address that is mapped.
    function automatic logic [32:0] read_reg(input logic [7:0] a);
        logic [32:0] r;
        r = 33'h0_0000_0000;
        if (a[1:0] == 2'b00) begin
            case (a)
                OFS_CTRL:    r = {1'b1, ctrl_q};
                OFS_STAT:    r = {1'b1, stat_q};
                OFS_MASK:    r = {1'b1, mask_q};
                OFS_WD_CTRL: r = {1'b1, 31'h0, wd_state_q == WD_RUN};
                OFS_WD_FEED: r = {1'b1, 32'h0};
                OFS_WD_WARN: r = {1'b1, 22'h0, wd_warn_q};
                OFS_WD_CNT:  r = {1'b1, 22'h0, wd_cnt_q};
                default: begin
                    case (a[7:4])
                        BANK_TCTL:  r = {1'b1, 30'h0, tctl_q[a[3:2]]};
                        BANK_MATCH: r = {1'b1, match_q[a[3:2]]};
                        BANK_COUNT: r = {1'b1, cnt[a[3:2]]};
                        default:    r = 33'h0_0000_0000;
                    endcase
                end
            endcase
        end
        return r;
    endfunction : read_reg

    // A transfer completes at the edge where pready is seen high.
    assign access   = psel & penable & pready;
    assign wr       = access & pwrite;
    assign feed     = wr && paddr == OFS_WD_FEED;
    assign gate     = ctrl_q[CTRL_GATE];
    assign slow_gated = slow_tick & gate;
    assign fast_gated = fast_tick & gate;

    // Read word follows the address and every register that the decode reads.
    always_comb begin
        rd_word = read_reg(paddr);
    end

    // One wait state: answer is staged during the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & !pready;
            if (psel && penable && !pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_word[31:0];
                pslverr <= !rd_word[32];
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Global control: gate, system clock choice and chaining.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else if (wr && paddr == OFS_CTRL) begin
            ctrl_q <= pwdata & CTRL_WMASK;
        end
    end

    // Mask register shares the status layout.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 32'h0000_0000;
        end else if (wr && paddr == OFS_MASK) begin
            mask_q <= pwdata & STAT_MASK;
        end
    end

    // Sticky events, cleared by writing ones; a new event wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 32'h0000_0000;
        end else begin
            stat_q <= ((wr && paddr == OFS_STAT) ? stat_q & ~pwdata : stat_q)
                      | {27'h0, warn_evt, hit};
        end
    end

    // Per-timer mode and match registers; writing a mode re-arms it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                tctl_q[i]  <= 2'b00;
                match_q[i] <= MATCH_RST;
            end
            start <= 4'h0;
        end else begin
            start <= 4'h0;
            if (wr && paddr[7:4] == BANK_TCTL && paddr[1:0] == 2'b00) begin
                tctl_q[paddr[3:2]] <= pwdata[1:0];
                start[paddr[3:2]]  <= 1'b1;
            end
            if (wr && paddr[7:4] == BANK_MATCH && paddr[1:0] == 2'b00) begin
                match_q[paddr[3:2]] <= pwdata;
            end
        end
    end

    // Slow tick base: the slow oscillator divided by two, never gated.
    tick_divider #(.W(DIV_W)) u_slow_div (
        .clk    (pclk),
        .rst_n  (presetn),
        .step   (1'b1),
        .len    (DIV_W'(SLOW_DIV - 1)),
        .tick_q (slow_tick)
    );

    // System clock rate for the wide timers, set by software.
    tick_divider #(.W(DIV_W)) u_fast_div (
        .clk    (pclk),
        .rst_n  (presetn),
        .step   (1'b1),
        .len    (fast_len(ctrl_q[CTRL_SYS +: 2])),
        .tick_q (fast_tick)
    );

    // Watchdog rate: a further divide by 64 of the slow tick.
    tick_divider #(.W(DIV_W)) u_wd_div (
        .clk    (pclk),
        .rst_n  (presetn),
        .step   (slow_tick),
        .len    (DIV_W'(WD_PRESCALE - 1)),
        .tick_q (wd_tick)
    );

    // Four match timers; the second narrow one may count on the first.
    for (genvar gi = 0; gi < 4; gi++) begin : g_tmr
        localparam int unsigned W = (gi < 2) ? SLOW_W : FAST_W;
        logic [W-1:0] c;
        logic         tk;
        if (gi == 1) begin : g_chain
            assign tk = ctrl_q[CTRL_CHAIN] ? hit[0] : slow_gated;
        end else if (gi == 0) begin : g_slow
            assign tk = slow_gated;
        end else begin : g_fast
            assign tk = fast_gated;
        end
        match_timer #(.W(W)) u_tmr (
            .clk      (pclk),
            .rst_n    (presetn),
            .tick     (tk),
            .en       (tctl_q[gi][TCTL_EN]),
            .free_run (tctl_q[gi][TCTL_FREE]),
            .start    (start[gi]),
            .match    (match_q[gi][W-1:0]),
            .count_q  (c),
            .hit_q    (hit[gi])
        );
        assign cnt[gi] = 32'(c);
    end

    // Warning threshold for the non-maskable interrupt.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_warn_q <= WARN_RST;
        end else if (wr && paddr == OFS_WD_WARN) begin
            wd_warn_q <= pwdata[WD_W-1:0];
        end
    end

    assign warn_evt = wd_state_q == WD_RUN && wd_tick && !feed
                      && wd_cnt_q == wd_warn_q;

    // Supervision countdown: off until enabled, fires a reset at full count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_state_q <= WD_OFF;
            wd_cnt_q   <= '0;
            hold_q     <= '0;
        end else begin
            case (wd_state_q)
                WD_OFF: begin
                    wd_cnt_q <= '0;
                    if (wr && paddr == OFS_WD_CTRL && pwdata[0]) begin
                        wd_state_q <= WD_RUN;
                    end
                end
                WD_RUN: begin
                    if (feed) begin
                        wd_cnt_q <= '0;
                    end else if (wd_tick) begin
                        if (wd_cnt_q == WD_MAX) begin
                            wd_state_q <= WD_FIRE;
                            hold_q <= HOLD_W'(RESET_HOLD_CYC - 1);
                        end else begin
                            wd_cnt_q <= wd_cnt_q + 1'b1;
                        end
                    end
                end
                WD_FIRE: begin
                    if (hold_q == '0) begin
                        wd_state_q <= WD_OFF;
                    end else begin
                        hold_q <= hold_q - 1'b1;
                    end
                end
                default: wd_state_q <= WD_OFF;
            endcase
        end
    end

    // Output lines, each from its own flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q       <= 1'b0;
            nmi_q       <= 1'b0;
            sys_reset_q <= 1'b0;
            timer_out_q <= 1'b0;
        end else begin
            irq_q       <= |(stat_q[3:0] & mask_q[3:0]);
            nmi_q       <= stat_q[STAT_WD];
            sys_reset_q <= wd_state_q == WD_FIRE;
            timer_out_q <= |hit;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_wait: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB answer not given after one wait state.");

    chk_feed_restart: assert property (
        feed && wd_state_q == WD_RUN |=> wd_cnt_q == '0)
        else $error("Reload did not restart the watchdog count.");

    chk_wd_fires: assert property (
        wd_state_q == WD_RUN && wd_tick && !feed && wd_cnt_q == WD_MAX
        |=> ##1 sys_reset_q [*8])
        else $error("Expired watchdog did not hold system reset.");

    chk_wd_comeback: assert property (
        $fell(sys_reset_q) |-> wd_state_q == WD_OFF && !$past(wd_state_q == WD_RUN))
        else $error("Watchdog not disabled after its reset.");

    chk_nmi_warn: assert property (
        warn_evt |=> stat_q[STAT_WD] ##1 nmi_q)
        else $error("Watchdog warning did not reach the NMI line.");

    chk_irq_mask: assert property (
        ##1 irq_q == $past(|(stat_q[3:0] & mask_q[3:0])))
        else $error("Interrupt line disagrees with status and mask.");

    chk_out_line: assert property (
        |hit |=> timer_out_q)
        else $error("Match event missing on the common output line.");

    chk_gate_off: assert property (
        !gate && tctl_q[2][TCTL_EN] && !start[2] |=> $stable(cnt[2]))
        else $error("Gated timer kept counting.");

    chk_stat_sticky: assert property (
        stat_q[0] && !(wr && paddr == OFS_STAT && pwdata[0]) |=> stat_q[0])
        else $error("Timeout status bit lost without a clear.");

endmodule : general_timers

// ===== include/timer_pkg.sv
/*
 * Shared constants for the timer and supervision block: register offsets,
 * field positions, reset values, rates and the watchdog state encoding.
 * Assumes the block runs on one 40 MHz bus clock; slower rates are enables.
 */
package timer_pkg;

    // Bus clock and derived oscillator tick rates.
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned CLK_NS       = 25;
    localparam int unsigned SLOW_TICK_HZ = 182_500;
    localparam int unsigned FAST_OSC_HZ  = 20_000_000;
    localparam int unsigned SLOW_DIV     = CLK_HZ / SLOW_TICK_HZ;
    localparam int unsigned FAST_DIV     = CLK_HZ / FAST_OSC_HZ;
    localparam int unsigned WD_PRESCALE  = 64;
    localparam int unsigned DIV_W        = 8;

    // Counter widths.
    localparam int unsigned SLOW_W = 12;
    localparam int unsigned FAST_W = 32;
    localparam int unsigned WD_W   = 10;
    localparam logic [9:0]  WD_MAX = 10'h3FF;

    // Length of the system reset pulse.
    localparam int unsigned RESET_HOLD_NS  = 400;
    localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_NS / CLK_NS;
    localparam int unsigned HOLD_W         = 5;

    // Register offsets; per-timer banks step by four bytes.
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STAT    = 8'h04;
    localparam logic [7:0] OFS_MASK    = 8'h08;
    localparam logic [7:0] OFS_WD_CTRL = 8'h0C;
    localparam logic [7:0] OFS_WD_FEED = 8'h10;
    localparam logic [7:0] OFS_WD_WARN = 8'h14;
    localparam logic [7:0] OFS_WD_CNT  = 8'h18;
    localparam logic [3:0] BANK_TCTL   = 4'h2;
    localparam logic [3:0] BANK_MATCH  = 4'h3;
    localparam logic [3:0] BANK_COUNT  = 4'h4;

    // Field positions.
    localparam int unsigned CTRL_GATE  = 0;
    localparam int unsigned CTRL_SYS   = 1;
    localparam int unsigned CTRL_CHAIN = 3;
    localparam int unsigned TCTL_EN    = 0;
    localparam int unsigned TCTL_FREE  = 1;
    localparam int unsigned STAT_WD    = 4;

    // Reset and write-mask values.
    localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_000F;
    localparam logic [31:0] STAT_MASK  = 32'h0000_001F;
    localparam logic [31:0] MATCH_RST  = 32'hFFFF_FFFF;
    localparam logic [9:0]  WARN_RST   = 10'h300;

    // System clock selection for the 32-bit timers.
    typedef enum logic [1:0] {
        SYS_20 = 2'b00,
        SYS_10 = 2'b01,
        SYS_5  = 2'b11
    } sysclk_sel_t;

    // Watchdog states, Gray coded along off, run, fire.
    typedef enum logic [1:0] {
        WD_OFF  = 2'b00,
        WD_RUN  = 2'b01,
        WD_FIRE = 2'b11
    } wd_state_t;

endpackage : timer_pkg

// ===== hw/tick_divider.sv
/*
 * Enable-pulse divider: counts step pulses and emits one tick pulse
 * every len+1 steps. Assumes len is at least one and held steady.
 */
`timescale 1ns/1ps
module tick_divider #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         step,
    input  wire logic [W-1:0] len,
    output logic              tick_q
);

    logic [W-1:0] cnt_q;

    // Wrap on reaching len so a shortened length takes effect at once.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (step) begin
            if (cnt_q >= len) begin
                cnt_q  <= '0;
                tick_q <= 1'b1;
            end else begin
                cnt_q  <= cnt_q + 1'b1;
                tick_q <= 1'b0;
            end
        end else begin
            tick_q <= 1'b0;
        end
    end

    chk_tick_single_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        tick_q |=> !tick_q)
        else $error("Divider tick lasted more than one cycle.");

endmodule : tick_divider

// ===== hw/match_timer.sv
/*
 * One match timer: counts ticks up from zero and pulses hit when the count
 * equals the match value, then stops or restarts as the mode asks.
 * Assumes tick is a one-cycle enable on the same clock.
 */
`timescale 1ns/1ps
module match_timer #(
    parameter int unsigned W = 12
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic         en,
    input  wire logic         free_run,
    input  wire logic         start,
    input  wire logic [W-1:0] match,
    output logic [W-1:0]      count_q,
    output logic              hit_q
);

    logic done_q;

    // Single-shot parks on the match value; free-running wraps to zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            done_q  <= 1'b0;
            hit_q   <= 1'b0;
        end else begin
            hit_q <= 1'b0;
            if (!en || start) begin
                count_q <= '0;
                done_q  <= 1'b0;
            end else if (tick && !done_q) begin
                if (count_q == match) begin
                    hit_q <= 1'b1;
                    if (free_run) begin
                        count_q <= '0;
                    end else begin
                        done_q <= 1'b1;
                    end
                end else begin
                    count_q <= count_q + 1'b1;
                end
            end
        end
    end

    chk_match_hit: assert property (
        @(posedge clk) disable iff (!rst_n)
        en && !start && tick && !done_q && count_q == match |=> hit_q)
        else $error("Match reached without a hit pulse.");

    chk_oneshot_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        done_q && en && !start |=> $stable(count_q) && !hit_q)
        else $error("Single-shot timer moved after its match.");

endmodule : match_timer

// ===== tb/apb_master_model.sv
/*
 * Processor-side bus master model: issues single read and write transfers
 * on the register bus of the timer block.
 * Assumes pclk is free running and the slave answers with pready.
 */
`timescale 1ns/1ps
module apb_master_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    // Idle bus at time zero.
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // One transfer: setup, access held until pready, then release.
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        // Released lines show changed values so stale data cannot match.
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer

    // Write a register word.
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, a, d, q, e);
    endtask : write

    // Read a register word with its error flag.
    task automatic read(input logic [7:0] a, output logic [31:0] q,
                        output logic e);
        xfer(1'b0, a, 32'h0000_0000, q, e);
    endtask : read
endmodule : apb_master_model

// ===== tb/general_timers_tb_top.sv
/*
 * Self-checking bench for the timer block: register access, timer rates,
 * modes, chaining, gating, interrupts and the supervision countdown.
 * Assumes the bus master model drives every bus input of the block except pclk and presetn, which the bench drives.
 */
`timescale 1ns/1ps
module general_timers_tb_top;
    import timer_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        irq_q, nmi_q, sys_reset_q, timer_out_q;
    int          num_errors = 0;
    int          total_checks = 0;
    int          pulses = 0;
    int          p0;
    int          divs[3] = '{2, 4, 8};
    logic [1:0]  sels[3] = '{2'b00, 2'b01, 2'b11};

    // Bus clock, 25 ns period.
    always #12.5 pclk = ~pclk;

    // Count match pulses on the shared output line.
    always @(posedge pclk) if (timer_out_q === 1'b1) pulses <= pulses + 1;

    apb_master_model master (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    general_timers dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_q(irq_q),
        .nmi_q(nmi_q), .sys_reset_q(sys_reset_q),
        .timer_out_q(timer_out_q));

    // Compare one value and count the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Read a mapped register and compare it.
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        master.read(a, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0000_0000);
    endtask : rdchk

    // Print the counts and the verdict, then stop.
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // Cut a hang short well beyond the expected run length.
    initial begin
        #2_000_000;
        num_errors++;
        test_done();
    end

    // Main test sequence.
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFS_CTRL, CTRL_RST);
        rdchk(8'h38, MATCH_RST);
        rdchk(OFS_WD_WARN, {22'h0, WARN_RST});
        rdchk(OFS_STAT, 32'h0000_0000);
        master.read(8'hFC, rd, err);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        // Closed clock gate keeps an enabled timer at zero.
        master.write(OFS_CTRL, 32'h0000_0000);
        master.write(8'h38, 32'h0000_0003);
        master.write(8'h28, 32'h0000_0003);
        repeat (40) @(posedge pclk);
        rdchk(8'h48, 32'h0000_0000);
        // Free-running timer 2 at each system clock: 10 periods a window.
        for (int i = 0; i < 3; i++) begin
            master.write(OFS_CTRL, {29'h0, sels[i], 1'b1});
            master.write(8'h28, 32'h0000_0003);
            repeat (10) @(posedge pclk);
            p0 = pulses;
            repeat (40 * divs[i]) @(posedge pclk);
            chk(32'(pulses - p0 >= 9 && pulses - p0 <= 11), 1);
        end
        master.write(8'h28, 32'h0000_0000);
        master.write(OFS_STAT, 32'h0000_001F);
        // Single-shot timer 3 with its interrupt masked, then unmasked.
        master.write(OFS_MASK, 32'h0000_0000);
        master.write(8'h3C, 32'h0000_0005);
        master.write(8'h2C, 32'h0000_0001);
        repeat (60) @(posedge pclk);
        rdchk(8'h4C, 32'h0000_0005);
        rdchk(OFS_STAT, 32'h0000_0008);
        chk({31'h0, irq_q}, 32'h0000_0000);
        master.write(OFS_MASK, 32'h0000_0008);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq_q}, 32'h0000_0001);
        master.write(OFS_STAT, 32'h0000_0008);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq_q}, 32'h0000_0000);
        repeat (40) @(posedge pclk);
        rdchk(OFS_STAT, 32'h0000_0000);
        // Timer 1 chained on timer 0: one timer 0 period in 1000 cycles.
        master.write(OFS_CTRL, 32'h0000_0009);
        master.write(8'h30, 32'h0000_0003);
        master.write(8'h34, 32'h0000_0008);
        master.write(8'h24, 32'h0000_0003);
        master.write(8'h20, 32'h0000_0003);
        repeat (1000) @(posedge pclk);
        rdchk(8'h44, 32'h0000_0001);
        master.write(8'h20, 32'h0000_0000);
        master.write(8'h24, 32'h0000_0000);
        master.write(OFS_CTRL, 32'h0000_0001);
        master.write(OFS_STAT, 32'h0000_001F);
        // Supervision countdown: warning at a low count, then a reload.
        master.write(OFS_WD_WARN, 32'h0000_0001);
        master.write(OFS_WD_CTRL, 32'h0000_0001);
        rdchk(OFS_WD_CTRL, 32'h0000_0001);
        for (int i = 0; i < 30000 && nmi_q !== 1'b1; i++) @(posedge pclk);
        chk({31'h0, nmi_q}, 32'h0000_0001);
        chk({31'h0, irq_q}, 32'h0000_0000);
        chk({31'h0, sys_reset_q}, 32'h0000_0000);
        rdchk(OFS_STAT, 32'h0000_0010);
        master.write(OFS_WD_FEED, 32'h0000_0001);
        rdchk(OFS_WD_CNT, 32'h0000_0000);
        test_done();
    end
endmodule : general_timers_tb_top
